// ### hw/acc_pkg.sv
package acc_pkg;
  // ==========================================================================
  // register map: printed offsets are word indices, byte address = 4 * index
  // ==========================================================================
  localparam logic [7:0] IDX_CTRL     = 8'h08;
  localparam logic [7:0] IDX_RESULT   = 8'h09;
  localparam logic [7:0] IDX_PINCFG   = 8'h0A;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h0B;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADR_CTRL     = {IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADR_RESULT   = {IDX_RESULT[5:0], 2'b00};
  localparam logic [7:0] ADR_PINCFG   = {IDX_PINCFG[5:0], 2'b00};
  localparam logic [7:0] ADR_IRQ_STAT = {IDX_IRQ_STAT[5:0], 2'b00};
  localparam logic [7:0] ADR_IRQ_MASK = {IDX_IRQ_MASK[5:0], 2'b00};

  // ==========================================================================
  // converter_control_status, pin config and interrupt status/mask field positions
  // ==========================================================================
  localparam int CTRL_PWR   = 0;
  localparam int CTRL_DONE  = 1;
  localparam int CTRL_GO    = 2;
  localparam int CTRL_CH_LO = 3;
  localparam int CTRL_GP    = 5;
  localparam int CTRL_CK_LO = 6;
  localparam int PCFG_LO    = 0;
  localparam int STAT_DONE  = 0;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [1:0] RST_PCFG   = 2'h0;
  localparam logic [0:0] RST_STAT   = 1'h0;
  localparam logic [0:0] RST_MASK   = 1'h0;

  // ==========================================================================
  // conversion timing, in oscillator cycles and conversion-clock periods
  // ==========================================================================
  localparam logic [5:0] DIV_2      = 6'h02;
  localparam logic [5:0] DIV_8      = 6'h08;
  localparam logic [5:0] DIV_32     = 6'h20;
  localparam logic [3:0] CONV_TADS  = 4'hA;
  localparam logic [3:0] REST_TADS  = 4'h2;
  localparam logic [3:0] FIRST_BIT  = 4'h1;
  localparam logic [3:0] LAST_BIT   = 4'h8;
  localparam logic [7:0] SAR_MSB    = 8'h80;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ACC_CK_DIV2  = 2'b00,
    ACC_CK_DIV8  = 2'b01,
    ACC_CK_DIV32 = 2'b10,
    ACC_CK_RC    = 2'b11
  } acc_clk_sel_t;

  typedef enum logic [1:0] {
    ACC_SAMPLE  = 2'b00,
    ACC_CONVERT = 2'b01,
    ACC_REST    = 2'b10
  } acc_state_t;
endpackage : acc_pkg

// ### hw/acc_tad_gen.sv
`timescale 1ns/1ps
module acc_tad_gen (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // internal rc oscillator, asynchronous
  input  wire logic rc_osc_i,
  // conversion clock to the sequencer
  acc_tad_if.gen    tad
);
  logic [5:0] div_cnt_q;
  logic [5:0] div_len;
  logic       rc_meta_q;
  logic       rc_sync_q;
  logic       rc_prev_q;
  logic       div_end;

  // ==========================================================================
  // divider selection
  // ==========================================================================
  always_comb begin
    unique case (tad.clk_sel)
      acc_pkg::ACC_CK_DIV2:  div_len = acc_pkg::DIV_2;
      acc_pkg::ACC_CK_DIV8:  div_len = acc_pkg::DIV_8;
      acc_pkg::ACC_CK_DIV32: div_len = acc_pkg::DIV_32;
      acc_pkg::ACC_CK_RC:    div_len = acc_pkg::DIV_32;
    endcase
  end

  assign div_end = (div_cnt_q == div_len - 6'h01);

  // conversion period counted from oscillator cycles
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt_q <= 6'h00;
    end else if (!tad.run || div_end) begin
      div_cnt_q <= 6'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  // ==========================================================================
  // rc oscillator synchroniser and edge detect
  // ==========================================================================
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rc_meta_q <= 1'b0;
      rc_sync_q <= 1'b0;
      rc_prev_q <= 1'b0;
    end else begin
      rc_meta_q <= rc_osc_i;
      rc_sync_q <= rc_meta_q;
      rc_prev_q <= rc_sync_q;
    end
  end

  // one tick per conversion-clock period, only while converting or resting (any state but sample)
  always_comb begin
    if (tad.clk_sel == acc_pkg::ACC_CK_RC) begin
      tad.tick = tad.run && rc_sync_q && !rc_prev_q;
    end else begin
      tad.tick = tad.run && div_end;
    end
  end
endmodule : acc_tad_gen

// ### hw/acc_tad_if.sv
`timescale 1ns/1ps
interface acc_tad_if;
  acc_pkg::acc_clk_sel_t clk_sel;
  logic                  run;
  logic                  tick;

  modport gen (input clk_sel, input run, output tick);
  modport user(output clk_sel, output run, input tick);
endinterface : acc_tad_if

// ### hw/acc_top.sv
`timescale 1ns/1ps
module acc_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  // axi4-lite write response
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic [1:0]       s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [7:0]  s_axi_araddr_i,
  // axi4-lite read data
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  // analog front end
  input  wire logic        cmp_i,
  input  wire logic        rc_osc_i,
  output logic             power_on_o,
  output logic             sample_o,
  output logic [1:0]       channel_o,
  output logic [7:0]       trial_code_o,
  output logic             vref_ext_o,
  output logic [3:0]       pin_analog_o,
  // interrupt
  output logic             irq_o
);
  acc_tad_if tad_if ();

  acc_pkg::acc_state_t state_q;
  logic                pwr_q, done_q, go_q, gp_q, stat_q, mask_q;
  logic [1:0]          ch_q, cks_q, pcfg_q;
  logic [7:0]          result_q, sar_q, bit_q, trial_q;
  logic [3:0]          tad_cnt_q;
  logic                cmp_q;
  logic                aw_held_q, w_held_q, wr_lane_q, bvalid_q, rvalid_q;
  logic [7:0]          wr_addr_q, wr_data_q;
  logic [1:0]          bresp_q, rresp_q;
  logic [31:0]         rdata_q;
  logic                wr_en, wr_ctrl, start, decide, finish, abort, ch_valid;
  logic [7:0]          sar_d, ctrl_rd;

  acc_tad_gen u_tad (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .rc_osc_i (rc_osc_i),
    .tad      (tad_if.gen)
  );

  assign tad_if.clk_sel = acc_pkg::acc_clk_sel_t'(cks_q);
  assign tad_if.run     = (state_q != acc_pkg::ACC_SAMPLE);

  // ==========================================================================
  // axi4-lite write path
  // ==========================================================================
  assign s_axi_awready_o = !aw_held_q && !bvalid_q;
  assign s_axi_wready_o  = !w_held_q && !bvalid_q;
  assign wr_en           = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_lane_q <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_q <= 1'b1;
        wr_addr_q <= s_axi_awaddr_i;
      end else if (wr_en) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_q  <= 1'b1;
        wr_data_q <= s_axi_wdata_i[7:0];
        wr_lane_q <= s_axi_wstrb_i[0];
      end else if (wr_en) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= acc_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      unique case (wr_addr_q)
        acc_pkg::ADR_CTRL, acc_pkg::ADR_RESULT, acc_pkg::ADR_PINCFG,
        acc_pkg::ADR_IRQ_STAT, acc_pkg::ADR_IRQ_MASK: bresp_q <= acc_pkg::RESP_OKAY;
        default: bresp_q <= acc_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o  = bresp_q;
  assign wr_ctrl        = wr_en && wr_lane_q && (wr_addr_q == acc_pkg::ADR_CTRL);

  // ==========================================================================
  // axi4-lite read path
  // ==========================================================================
  assign ctrl_rd = {cks_q, gp_q, ch_q, go_q, done_q, pwr_q};
  assign s_axi_arready_o = !rvalid_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= acc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_q <= 1'b1;
      rresp_q  <= acc_pkg::RESP_OKAY;
      unique case (s_axi_araddr_i)
        acc_pkg::ADR_CTRL:     rdata_q <= {24'h00_0000, ctrl_rd};
        acc_pkg::ADR_RESULT:   rdata_q <= {24'h00_0000, result_q};
        acc_pkg::ADR_PINCFG:   rdata_q <= {30'h0000_0000, pcfg_q};
        acc_pkg::ADR_IRQ_STAT: rdata_q <= {31'h0000_0000, stat_q};
        acc_pkg::ADR_IRQ_MASK: rdata_q <= {31'h0000_0000, mask_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= acc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o  = rdata_q;
  assign s_axi_rresp_o  = rresp_q;

  // ==========================================================================
  // control registers
  // ==========================================================================
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_q  <= acc_pkg::RST_CTRL[acc_pkg::CTRL_PWR];
      ch_q   <= acc_pkg::RST_CTRL[acc_pkg::CTRL_CH_LO +: 2];
      gp_q   <= acc_pkg::RST_CTRL[acc_pkg::CTRL_GP];
      cks_q  <= acc_pkg::RST_CTRL[acc_pkg::CTRL_CK_LO +: 2];
      pcfg_q <= acc_pkg::RST_PCFG;
      mask_q <= acc_pkg::RST_MASK;
    end else if (wr_en && wr_lane_q) begin
      unique case (wr_addr_q)
        acc_pkg::ADR_CTRL: begin
          pwr_q <= wr_data_q[acc_pkg::CTRL_PWR];
          ch_q  <= wr_data_q[acc_pkg::CTRL_CH_LO +: 2];
          gp_q  <= wr_data_q[acc_pkg::CTRL_GP];
          cks_q <= wr_data_q[acc_pkg::CTRL_CK_LO +: 2];
        end
        acc_pkg::ADR_PINCFG:   pcfg_q <= wr_data_q[acc_pkg::PCFG_LO +: 2];
        acc_pkg::ADR_IRQ_MASK: mask_q <= wr_data_q[acc_pkg::STAT_DONE];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // conversion sequencer
  // ==========================================================================
  assign start  = wr_ctrl && wr_data_q[acc_pkg::CTRL_GO] && wr_data_q[acc_pkg::CTRL_PWR]
                  && (state_q == acc_pkg::ACC_SAMPLE);
  assign decide = (state_q == acc_pkg::ACC_CONVERT) && tad_if.tick
                  && (tad_cnt_q >= acc_pkg::FIRST_BIT) && (tad_cnt_q <= acc_pkg::LAST_BIT);
  assign finish = (state_q == acc_pkg::ACC_CONVERT) && tad_if.tick
                  && (tad_cnt_q == acc_pkg::CONV_TADS - 4'h1);
  assign abort  = (state_q != acc_pkg::ACC_SAMPLE) && !pwr_q;
  assign sar_d  = cmp_q ? (sar_q | bit_q) : sar_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q   <= acc_pkg::ACC_SAMPLE;
      tad_cnt_q <= 4'h0;
    end else if (abort) begin
      state_q   <= acc_pkg::ACC_SAMPLE;
      tad_cnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        acc_pkg::ACC_SAMPLE: begin
          if (start) begin
            state_q   <= acc_pkg::ACC_CONVERT;
            tad_cnt_q <= 4'h0;
          end
        end
        acc_pkg::ACC_CONVERT: begin
          if (finish) begin
            state_q   <= acc_pkg::ACC_REST;
            tad_cnt_q <= 4'h0;
          end else if (tad_if.tick) begin
            tad_cnt_q <= tad_cnt_q + 4'h1;
          end
        end
        acc_pkg::ACC_REST: begin
          if (tad_if.tick && tad_cnt_q == acc_pkg::REST_TADS - 4'h1) begin
            state_q <= acc_pkg::ACC_SAMPLE;
          end else if (tad_if.tick) begin
            tad_cnt_q <= tad_cnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= acc_pkg::ACC_SAMPLE;
        end
      endcase
    end
  end

  // successive approximation, one bit per conversion-clock period
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sar_q   <= 8'h00;
      bit_q   <= 8'h00;
      trial_q <= 8'h00;
    end else if (start) begin
      sar_q   <= 8'h00;
      bit_q   <= acc_pkg::SAR_MSB;
      trial_q <= acc_pkg::SAR_MSB;
    end else if (decide) begin
      sar_q   <= sar_d;
      bit_q   <= bit_q >> 1;
      trial_q <= sar_d | (bit_q >> 1);
    end
  end

  // comparator answers the registered trial code within a cycle: one sample flop keeps div 2
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmp_q <= 1'b0;
    end else begin
      cmp_q <= cmp_i;
    end
  end

  // ==========================================================================
  // go, done flag, result and interrupt status
  // ==========================================================================
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      go_q <= acc_pkg::RST_CTRL[acc_pkg::CTRL_GO];
    end else if (finish || abort) begin
      go_q <= 1'b0;
    end else if (start) begin
      go_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_q <= acc_pkg::RST_CTRL[acc_pkg::CTRL_DONE];
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (wr_ctrl) begin
      done_q <= wr_data_q[acc_pkg::CTRL_DONE];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_q <= acc_pkg::RST_RESULT;
    end else if (finish) begin
      result_q <= sar_q;
    end else if (wr_en && wr_lane_q && wr_addr_q == acc_pkg::ADR_RESULT) begin
      result_q <= wr_data_q;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_q <= acc_pkg::RST_STAT;
    end else if (finish) begin
      stat_q <= 1'b1;
    end else if (wr_en && wr_lane_q && wr_addr_q == acc_pkg::ADR_IRQ_STAT
                 && wr_data_q[acc_pkg::STAT_DONE]) begin
      stat_q <= 1'b0;
    end
  end

  assign irq_o = stat_q && mask_q;

  // ==========================================================================
  // analog side controls
  // ==========================================================================
  always_comb begin
    unique case (pcfg_q)
      2'b00: pin_analog_o = 4'hF;
      2'b01: pin_analog_o = 4'h7;
      2'b10: pin_analog_o = 4'h3;
      2'b11: pin_analog_o = 4'h0;
    endcase
  end

  assign ch_valid     = pin_analog_o[ch_q];
  assign vref_ext_o   = (pcfg_q == 2'b01);
  assign channel_o    = ch_q;
  assign power_on_o   = pwr_q;
  assign sample_o     = pwr_q && ch_valid && (state_q == acc_pkg::ACC_SAMPLE);
  assign trial_code_o = trial_q;
endmodule : acc_top

// ### testbench/acc_afe_model.sv
`timescale 1ns/1ps
module acc_afe_model #(
  parameter int RC_HALF_NS = 2000
) (
  // converter side
  input  wire logic        power_on_i,
  input  wire logic        sample_i,
  input  wire logic [1:0]  channel_i,
  input  wire logic [7:0]  trial_code_i,
  // analog sources, one byte per input
  input  wire logic [31:0] levels_i,
  output logic             cmp_o,
  output logic             rc_osc_o
);
  logic [7:0] held;

  initial rc_osc_o = 1'b0;
  always #(RC_HALF_NS) rc_osc_o = ~rc_osc_o;

  // track while sampling, hold otherwise
  always @* if (sample_i) held = levels_i[{channel_i, 3'b000} +: 8];

  // unpowered comparator output is meaningless, so it wanders
  assign cmp_o = power_on_i ? (held >= trial_code_i) : rc_osc_o;
endmodule : acc_afe_model

// ### testbench/acc_top_checker.sv
`timescale 1ns/1ps
module acc_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  // write channels
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [7:0]  s_axi_awaddr_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0]  s_axi_wstrb_i,
  // converter side
  input wire logic        sample_o,
  input wire logic        power_on_o,
  input wire logic [1:0]  channel_o,
  input wire logic [7:0]  trial_code_o,
  input wire logic        vref_ext_o,
  input wire logic [3:0]  pin_analog_o,
  input wire logic        irq_o
);
  // ==========================================================================
  // bus snooping
  logic       any_wr;
  logic       ctl_wr;
  logic       start;
  logic       conv_q;
  logic       div2_q;
  logic [1:0] ch_q;
  logic [9:0] cnt_q;

  assign any_wr = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  assign ctl_wr = any_wr && s_axi_wstrb_i[0] && (s_axi_awaddr_i == acc_pkg::ADR_CTRL);
  assign start  = ctl_wr && s_axi_wdata_i[0] && s_axi_wdata_i[2] && sample_o;

  // cycles spent away from tracking
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= sample_o ? 10'h000 : cnt_q + 10'h001;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_q <= 1'b0;
      div2_q <= 1'b0;
      ch_q   <= 2'h0;
    end else begin
      if (ctl_wr) begin
        ch_q <= s_axi_wdata_i[4:3];
      end
      if (start) begin
        conv_q <= 1'b1;
        div2_q <= (s_axi_wdata_i[7:6] == 2'h0);
      end else if ($rose(sample_o)) begin
        conv_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_pwr_off; !power_on_o |-> !sample_o; endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("tracking while off");
  property p_valid_ch; sample_o |-> power_on_o && pin_analog_o[channel_o]; endproperty
  a_valid_ch: assert property (p_valid_ch) else $error("tracking a digital pin");
  property p_vref; vref_ext_o == (pin_analog_o == 4'h7); endproperty
  a_vref: assert property (p_vref) else $error("reference choice wrong");
  property p_start; start |=> ##1 (!sample_o && trial_code_o == acc_pkg::SAR_MSB); endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_chan; ctl_wr && sample_o |=> ##1 channel_o == ch_q; endproperty
  a_chan: assert property (p_chan) else $error("channel not routed");
  property p_conv_len; $rose(irq_o) && conv_q && div2_q |-> cnt_q >= 18 && cnt_q <= 21; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_rest; $rose(irq_o) && conv_q && div2_q |-> !sample_o [*4] ##1 sample_o; endproperty
  a_rest: assert property (p_rest) else $error("resume delay wrong");
  property p_sticky; irq_o && !any_wr && !$past(any_wr) |=> irq_o; endproperty
  a_sticky: assert property (p_sticky) else $error("interrupt dropped");
endmodule : acc_chk

// ### testbench/acc_top_tb.sv
`timescale 1ns/1ps
module acc_top_tb;
  // ==========================================================================
  // signals
  logic        clk_i, arst_n_i, cmp_i, rc_osc_i, power_on_o, sample_o, vref_ext_o, irq_o;
  logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic        s_axi_rvalid_o, s_axi_rready_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, channel_o;
  logic [3:0]  s_axi_wstrb_i, pin_analog_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, trial_code_o;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, levels;
  int          errors, check_count;

  acc_top dut_u (.clk_i, .arst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i,
    .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o, .cmp_i, .rc_osc_i,
    .power_on_o, .sample_o, .channel_o, .trial_code_o, .vref_ext_o, .pin_analog_o, .irq_o);

  acc_afe_model afe_u (.power_on_i(power_on_o), .sample_i(sample_o), .channel_i(channel_o),
    .trial_code_i(trial_code_o), .levels_i(levels), .cmp_o(cmp_i), .rc_osc_o(rc_osc_i));

  // ==========================================================================
  // bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = acc_pkg::RESP_OKAY);
    @(posedge clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
    check(32'(s_axi_bresp_o), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = acc_pkg::RESP_OKAY);
    @(posedge clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
    check(s_axi_rdata_o, exp);
    check(32'(s_axi_rresp_o), 32'(er));
  endtask : rd

  task automatic wait_track;
    while (sample_o !== 1'b1) @(posedge clk_i);
  endtask : wait_track

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    check(32'(pin_analog_o), 32'hF);
    check(32'(power_on_o), 32'h0);
    rd(acc_pkg::ADR_CTRL, 32'(acc_pkg::RST_CTRL));
    rd(acc_pkg::ADR_RESULT, 32'(acc_pkg::RST_RESULT));
    rd(acc_pkg::ADR_PINCFG, 32'(acc_pkg::RST_PCFG));
    rd(acc_pkg::ADR_IRQ_STAT, 32'(acc_pkg::RST_STAT));
    rd(acc_pkg::ADR_IRQ_MASK, 32'(acc_pkg::RST_MASK));
    rd(8'h3C, 32'h0, acc_pkg::RESP_SLVERR);
    wr(8'h3C, 32'hFF, acc_pkg::RESP_SLVERR);
    wr(acc_pkg::ADR_CTRL, 32'h24);
    rd(acc_pkg::ADR_CTRL, 32'h20);
  endtask : t_reset

  task automatic t_pcfg;
    logic [3:0] pa [4] = '{4'hF, 4'h7, 4'h3, 4'h0};
    wr(acc_pkg::ADR_CTRL, 32'h19);
    wr(acc_pkg::ADR_PINCFG, 32'hFF);
    rd(acc_pkg::ADR_PINCFG, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(acc_pkg::ADR_PINCFG, 32'(i));
      check(32'(pin_analog_o), 32'(pa[i]));
      check(32'(vref_ext_o), 32'(i == 1));
      check(32'(sample_o), 32'(i == 0));
    end
    s_axi_wstrb_i <= 4'hE;
    wr(acc_pkg::ADR_PINCFG, 32'h0);
    rd(acc_pkg::ADR_PINCFG, 32'h3);
    s_axi_wstrb_i <= 4'hF;
    wr(acc_pkg::ADR_PINCFG, 32'h0);
  endtask : t_pcfg

  task automatic conv(input logic [1:0] ck, input logic [7:0] lv);
    int         n;
    int         p;
    logic [7:0] cw;
    cw = {ck, 1'b0, ck, 3'b001};
    p = (ck == 2'h3) ? 40 : (2 << (2 * ck));
    wr(acc_pkg::ADR_IRQ_STAT, 32'h1);
    levels[{ck, 3'b000} +: 8] <= lv;
    wr(acc_pkg::ADR_CTRL, 32'(cw));
    wait_track;
    repeat (4) @(posedge clk_i);
    wr(acc_pkg::ADR_CTRL, 32'(cw | 8'h04));
    check(32'(sample_o), 32'h0);
    check(32'(channel_o), 32'(ck));
    n = 0;
    while (irq_o !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(n > 9 * p && n <= 10 * p + 8), 32'h1);
    rd(acc_pkg::ADR_CTRL, 32'(cw | 8'h02));
    rd(acc_pkg::ADR_RESULT, 32'(lv));
    rd(acc_pkg::ADR_IRQ_STAT, 32'h1);
  endtask : conv

  task automatic t_irq;
    check(32'(irq_o), 32'h1);
    wr(acc_pkg::ADR_IRQ_MASK, 32'h0);
    check(32'(irq_o), 32'h0);
    wr(acc_pkg::ADR_IRQ_MASK, 32'h1);
    wr(acc_pkg::ADR_IRQ_STAT, 32'h0);
    check(32'(irq_o), 32'h1);
    wr(acc_pkg::ADR_IRQ_STAT, 32'h1);
    check(32'(irq_o), 32'h0);
    rd(acc_pkg::ADR_IRQ_STAT, 32'h0);
  endtask : t_irq

  task automatic t_abort;
    wr(acc_pkg::ADR_CTRL, 32'h89);
    wait_track;
    wr(acc_pkg::ADR_CTRL, 32'h8D);
    repeat (40) @(posedge clk_i);
    wr(acc_pkg::ADR_CTRL, 32'h88);
    rd(acc_pkg::ADR_CTRL, 32'h88);
    rd(acc_pkg::ADR_RESULT, 32'h01);
    check(32'({power_on_o, sample_o, irq_o}), 32'h0);
  endtask : t_abort

  // ==========================================================================
  // run control
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    conclude;
  end

  initial begin
    static logic [7:0] lvs [4] = '{8'hA5, 8'h3C, 8'hFF, 8'h01};
    arst_n_i = 1'b0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h0;
    s_axi_awaddr_i = 8'h00;
    s_axi_araddr_i = 8'h00;
    s_axi_wdata_i = 32'h0;
    s_axi_wstrb_i = 4'hF;
    levels = 32'h0;
    errors = 0;
    check_count = 0;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset;
    t_pcfg;
    wr(acc_pkg::ADR_IRQ_MASK, 32'h1);
    for (int i = 0; i < 4; i++) conv(2'(i), lvs[i]);
    t_irq;
    t_abort;
    conclude;
  end
endmodule : acc_top_tb

bind acc_top acc_chk chk_u (.clk_i, .arst_n_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_awaddr_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
  .sample_o, .power_on_o, .channel_o, .trial_code_o, .vref_ext_o, .pin_analog_o, .irq_o);
